// >>> ast_regs.svh
// Constants for the asynchronous serial transmitter and its receiver end
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// Character framing
`define AST_DATA_BITS_8   4'h8
`define AST_DATA_BITS_9   4'h9
`define AST_LINE_IDLE     1'h1
`define AST_LINE_START    1'h0

// Baud generator reset values and count width
`define AST_BAUD_DIV_RST  16'h0000
`define AST_BAUD_W        18

// Status/control reset values
`define AST_SHIFT_EMPTY_RST 1'h1
`define AST_TXIF_RST        1'h0

`endif

// >>> ast_pkg.sv
// Types shared by the transmitter and the receiving end
`default_nettype none
package ast_pkg;
	typedef enum logic [1:0] {
		AST_IDLE  = 2'b00,
		AST_START = 2'b01,
		AST_DATA  = 2'b10,
		AST_STOP  = 2'b11
	} ast_state_t;

	typedef logic [8:0] ast_char_t;
endpackage : ast_pkg
`default_nettype wire

// >>> ast_link_if.sv
// Serial line between the transmitter and the remote receiver
`timescale 1ns/1ps
`default_nettype none
interface ast_link_if;
	logic tx_line;
	modport transmitter (output tx_line);
	modport receiver    (input  tx_line);
endinterface : ast_link_if
`default_nettype wire

// >>> ast_tx.sv
// Transmit end: holding register, shift register, baud divider, status
//
// Contract
// R1: Shift-empty flag set when shift register empty
// R2: Flag stays clear until stop bit leaves
// R3: Shift-empty flag drives no interrupt
// R4: Shift register has no software access
// R5: Nine-bit mode shifts nine data bits
// R6: Ninth bit is MSB, written first
// R7: Holding write moves all nine bits
// R8: Set ninth bit marks an address
// R9: Software programs divisor before sending
// R10: Async mode needs port enable, clocked off
// R11: Polarity invert flips transmit output
// R12: Transmit enable sets interrupt flag
// R13: Interrupt when flag and three enables set
// R14: Holding write starts the character
// R15: Idle high, start, LSB first, stop
// R16: Flag high while holding register empty; the code holds it high only while the transmitter is active
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module ast_tx (
	input  wire logic                i_mclk,
	input  wire logic                i_rst,
	input  wire logic [7:0]          i_baud_div_low,
	input  wire logic [7:0]          i_baud_div_high,
	input  wire logic                i_high_baud_select,
	input  wire logic                i_wide_baud_divisor_select,
	input  wire logic                i_clocked_mode_select,
	input  wire logic                i_serial_port_enable,
	input  wire logic                i_nine_bit_transmit_enable,
	input  wire logic                i_ninth_transmit_bit,
	input  wire logic                i_transmit_polarity_invert,
	input  wire logic                i_transmit_enable_bit,
	input  wire logic                i_transmit_interrupt_enable,
	input  wire logic                i_global_interrupt_enable,
	input  wire logic                i_peripheral_interrupt_enable,
	input  wire logic                i_hold_wr,
	input  wire logic [7:0]          i_hold_data,
	output logic                     o_shift_reg_empty_flag,
	output logic                     o_transmit_interrupt_flag,
	output logic                     o_irq,
	ast_link_if.transmitter          link
);

	////////////////////////////////////////////////////////////////////////
	// Enables and baud divider
	ast_pkg::ast_state_t     state_reg;
	logic                    active;
	logic                    tick;
	logic [`AST_BAUD_W-1:0]  baud_cnt_reg;
	logic [`AST_BAUD_W-1:0]  baud_period;
	logic [15:0]             divisor;

	// Async operation only with clocked mode off and port enabled; see R10
	assign active = i_serial_port_enable & ~i_clocked_mode_select &
		i_transmit_enable_bit;

	// Bit period = (div+1) times 16, 4 or 1 depending on selects; see R9
	always_comb begin
		divisor = i_wide_baud_divisor_select ?
			{i_baud_div_high, i_baud_div_low} : {8'h00, i_baud_div_low};
		unique case ({i_wide_baud_divisor_select, i_high_baud_select})
			2'b00: baud_period = {divisor[13:0], 4'h0} + 18'h00010;
			2'b01,
			2'b10: baud_period = {divisor, 2'h0} + 18'h00004;
			2'b11: baud_period = {2'h0, divisor} + 18'h00001;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || state_reg == ast_pkg::AST_IDLE) begin
			baud_cnt_reg <= '0;
		end else if (tick) begin
			baud_cnt_reg <= '0;
		end else begin
			baud_cnt_reg <= baud_cnt_reg + 18'h00001;
		end
	end
	assign tick = (baud_cnt_reg == baud_period - 18'h00001);

	////////////////////////////////////////////////////////////////////////
	// Holding register
	ast_pkg::ast_char_t  hold_reg;
	logic                hold_full_reg;
	logic                load;

	// Holding register hands over whenever it is full, the shifter is idle and the transmitter is active
	assign load = hold_full_reg && state_reg == ast_pkg::AST_IDLE && active;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hold_full_reg <= 1'h0;
			hold_reg      <= '0;
		end else if (i_hold_wr && active) begin
			// Ninth bit sampled with the write: it must already be set; see R6
			hold_reg      <= {i_ninth_transmit_bit, i_hold_data}; // see R14
			hold_full_reg <= 1'h1;
		end else if (load) begin
			hold_full_reg <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift register: internal only, no port reads or writes it; see R4
	ast_pkg::ast_char_t shift_reg;
	logic [3:0]         bit_cnt_reg;
	logic [3:0]         nbits_reg;
	logic               line_reg;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg   <= ast_pkg::AST_IDLE;
			shift_reg   <= '0;
			bit_cnt_reg <= 4'h0;
			nbits_reg   <= `AST_DATA_BITS_8;
			line_reg    <= `AST_LINE_IDLE;
		end else begin
			unique case (state_reg)
				ast_pkg::AST_IDLE: begin
					line_reg <= `AST_LINE_IDLE; // see R15
					if (load) begin
						shift_reg <= hold_reg; // see R7
						nbits_reg <= i_nine_bit_transmit_enable ?
							`AST_DATA_BITS_9 : `AST_DATA_BITS_8; // see R5
						line_reg  <= `AST_LINE_START; // see R15
						state_reg <= ast_pkg::AST_START;
					end
				end
				ast_pkg::AST_START: begin
					if (tick) begin
						line_reg    <= shift_reg[0];
						shift_reg   <= shift_reg >> 1;
						bit_cnt_reg <= 4'h1;
						state_reg   <= ast_pkg::AST_DATA;
					end
				end
				ast_pkg::AST_DATA: begin
					if (tick) begin
						// LSB first; a set ninth bit goes out last as address mark
						// see R8
						if (bit_cnt_reg == nbits_reg) begin
							line_reg  <= `AST_LINE_IDLE;
							state_reg <= ast_pkg::AST_STOP;
						end else begin
							line_reg    <= shift_reg[0];
							shift_reg   <= shift_reg >> 1;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ast_pkg::AST_STOP: begin
					if (tick) begin
						state_reg <= ast_pkg::AST_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status, flags and output
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_shift_reg_empty_flag <= `AST_SHIFT_EMPTY_RST;
		end else begin
			// Clear on transfer, set only after stop bit ends; see R1 R2
			o_shift_reg_empty_flag <= !(load ||
				(state_reg != ast_pkg::AST_IDLE &&
				!(state_reg == ast_pkg::AST_STOP && tick)));
		end
	end

	// Flag follows holding-register emptiness while enabled; see R12 R16
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_transmit_interrupt_flag <= `AST_TXIF_RST;
		end else if (i_hold_wr && active) begin
			o_transmit_interrupt_flag <= 1'h0;
		end else begin
			o_transmit_interrupt_flag <= active && (!hold_full_reg || load);
		end
	end

	// Shift-empty flag is deliberately absent from this term; see R3
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_irq <= 1'h0;
		end else begin
			o_irq <= active && (!hold_full_reg || load) && !i_hold_wr &&
				i_transmit_interrupt_enable && i_global_interrupt_enable &&
				i_peripheral_interrupt_enable; // see R13
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			link.tx_line <= `AST_LINE_IDLE;
		end else begin
			link.tx_line <= i_serial_port_enable ?
				(line_reg ^ i_transmit_polarity_invert) : `AST_LINE_IDLE;
			// see R11
		end
	end

endmodule : ast_tx
`default_nettype wire

// >>> ast_rx.sv
// Remote receiver end: samples the line and presents each character that address detect keeps
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module ast_rx (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [17:0] i_bit_period,
	input  wire logic        i_nine_bit,
	input  wire logic        i_invert,
	input  wire logic        i_addr_detect,
	output logic             o_valid,
	output logic [8:0]       o_data,
	output logic             o_frame_err,
	ast_link_if.receiver     link
);
	ast_pkg::ast_state_t state_reg;
	logic [17:0]         cnt_reg;
	logic [3:0]          bit_cnt_reg;
	logic [8:0]          sh_reg;
	logic                line;
	logic [3:0]          nbits;

	assign line  = link.tx_line ^ i_invert;
	assign nbits = i_nine_bit ? `AST_DATA_BITS_9 : `AST_DATA_BITS_8;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg   <= ast_pkg::AST_IDLE;
			cnt_reg     <= 18'h00000;
			bit_cnt_reg <= 4'h0;
			sh_reg      <= 9'h000;
			o_valid     <= 1'h0;
			o_data      <= 9'h000;
			o_frame_err <= 1'h0;
		end else begin
			o_valid <= 1'h0;
			unique case (state_reg)
				ast_pkg::AST_IDLE: begin
					if (line == `AST_LINE_START) begin
						cnt_reg   <= {1'h0, i_bit_period[17:1]};
						state_reg <= ast_pkg::AST_START;
					end
				end
				ast_pkg::AST_START: begin
					if (cnt_reg == 18'h00000) begin
						cnt_reg     <= i_bit_period - 18'h00001;
						bit_cnt_reg <= 4'h0;
						state_reg   <= line ? ast_pkg::AST_IDLE :
							ast_pkg::AST_DATA;
					end else begin
						cnt_reg <= cnt_reg - 18'h00001;
					end
				end
				ast_pkg::AST_DATA: begin
					if (cnt_reg == 18'h00000) begin
						cnt_reg     <= i_bit_period - 18'h00001;
						sh_reg      <= {line, sh_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg + 4'h1 == nbits) begin
							state_reg <= ast_pkg::AST_STOP;
						end
					end else begin
						cnt_reg <= cnt_reg - 18'h00001;
					end
				end
				ast_pkg::AST_STOP: begin
					if (cnt_reg == 18'h00000) begin
						state_reg   <= ast_pkg::AST_IDLE;
						o_frame_err <= !line;
						// In nine-bit mode, address detect keeps only marked characters
						if (!(i_nine_bit && i_addr_detect && !sh_reg[8])) begin
							o_valid <= 1'h1;
							o_data  <= i_nine_bit ? sh_reg : {1'h0, sh_reg[8:1]};
						end
					end else begin
						cnt_reg <= cnt_reg - 18'h00001;
					end
				end
			endcase
		end
	end
endmodule : ast_rx
`default_nettype wire

// >>> ast_tx_chk.sv
// Concurrent checks on the transmitter end and its serial line
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module ast_tx_chk (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_tx_line,
	input wire logic i_hold_wr,
	input wire logic i_serial_port_enable,
	input wire logic i_clocked_mode_select,
	input wire logic i_transmit_enable_bit,
	input wire logic i_transmit_polarity_invert,
	input wire logic i_transmit_interrupt_enable,
	input wire logic i_global_interrupt_enable,
	input wire logic i_peripheral_interrupt_enable,
	input wire logic i_shift_reg_empty_flag,
	input wire logic i_transmit_interrupt_flag,
	input wire logic i_irq
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	wire logic act;
	wire logic ien;
	wire logic inv;
	wire logic mt;
	wire logic tf;
	assign act = i_serial_port_enable & ~i_clocked_mode_select
		& i_transmit_enable_bit;
	assign ien = i_transmit_interrupt_enable & i_global_interrupt_enable
		& i_peripheral_interrupt_enable;
	assign inv = i_transmit_polarity_invert;
	assign mt = i_shift_reg_empty_flag;
	assign tf = i_transmit_interrupt_flag;
	////////////////////////////////////////////////////////////////////////
	// The line lags the shifter state by one register stage
	idle_level_a: assert property ((mt && i_serial_port_enable &&
		$stable(inv)) [*2] |-> i_tx_line == (`AST_LINE_IDLE ^ inv))
		else $error("line not idle");
	start_bit_a: assert property (i_hold_wr && act && mt |->
		##2 !mt ##1 i_tx_line == (`AST_LINE_START ^ inv))
		else $error("no start");
	stop_end_a: assert property ($rose(mt) |->
		$past(i_tx_line) == (`AST_LINE_IDLE ^ inv)) else $error("early empty");
	txif_clear_a: assert property (i_hold_wr && act |=> !tf)
		else $error("flag kept on write");
	txif_back_a: assert property (i_hold_wr && act && mt && tf |-> ##2 tf)
		else $error("byte not moved on");
	enable_flag_a: assert property ($rose(i_transmit_enable_bit)
		&& i_serial_port_enable && !i_clocked_mode_select && mt
		|-> ##[1:2] tf) else $error("enable left flag low");
	txif_off_a: assert property (!i_transmit_enable_bit [*2] |-> !tf)
		else $error("flag while disabled");
	refuse_a: assert property (i_hold_wr && !act && mt |-> ##2 mt)
		else $error("write accepted while off");
	irq_on_a: assert property ((tf && ien) [*2] |-> i_irq)
		else $error("irq missing");
	// The request register sees the enables one cycle before it is read
	irq_off_a: assert property (!tf || !$past(ien) |-> !i_irq)
		else $error("irq without cause");
endmodule : ast_tx_chk
`default_nettype wire

// >>> ast_tx_tb_top.sv
// Testbench joining transmitter and receiver ends over the serial line
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module ast_tx_tb_top;
	logic i_mclk, i_rst, i_hold_wr, i_ninth_transmit_bit, rx_inv, adet;
	logic i_high_baud_select, i_wide_baud_divisor_select;
	logic i_clocked_mode_select, i_serial_port_enable;
	logic i_nine_bit_transmit_enable, i_transmit_polarity_invert;
	logic i_transmit_enable_bit, i_transmit_interrupt_enable;
	logic i_global_interrupt_enable, i_peripheral_interrupt_enable;
	logic o_shift_reg_empty_flag, o_transmit_interrupt_flag, o_irq, rv, rfe;
	logic [7:0] i_baud_div_low, i_baud_div_high, i_hold_data;
	logic [17:0] per;
	logic [8:0] rd;
	logic [9:0] q[$];
	int mismatches, n_tests, cyc, m;
	ast_link_if link();
	ast_tx u_ast_tx (.i_mclk, .i_rst, .i_baud_div_low, .i_baud_div_high,
		.i_high_baud_select, .i_wide_baud_divisor_select,
		.i_clocked_mode_select, .i_serial_port_enable,
		.i_nine_bit_transmit_enable, .i_ninth_transmit_bit,
		.i_transmit_polarity_invert, .i_transmit_enable_bit,
		.i_transmit_interrupt_enable, .i_global_interrupt_enable,
		.i_peripheral_interrupt_enable, .i_hold_wr, .i_hold_data,
		.o_shift_reg_empty_flag, .o_transmit_interrupt_flag, .o_irq,
		.link(link));
	ast_rx u_ast_rx (.i_mclk, .i_rst, .i_bit_period(per),
		.i_nine_bit(i_nine_bit_transmit_enable), .i_invert(rx_inv),
		.i_addr_detect(adet), .o_valid(rv), .o_data(rd),
		.o_frame_err(rfe), .link(link));
	ast_tx_chk u_ast_tx_chk (.i_mclk, .i_rst, .i_tx_line(link.tx_line),
		.i_hold_wr, .i_serial_port_enable, .i_clocked_mode_select,
		.i_transmit_enable_bit, .i_transmit_polarity_invert,
		.i_transmit_interrupt_enable, .i_global_interrupt_enable,
		.i_peripheral_interrupt_enable,
		.i_shift_reg_empty_flag(o_shift_reg_empty_flag),
		.i_transmit_interrupt_flag(o_transmit_interrupt_flag),
		.i_irq(o_irq));
	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_mclk);
	endtask : tick
	task automatic chk(input string nm, input logic [8:0] e,
		input logic [8:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// Waits for an idle line so that a mode change never cuts a frame
	task automatic cfg(input logic n, input logic v, input logic s);
		logic [7:0] d;
		int         k;
		d = 8'h02 + 8'($urandom % 4);
		k = 0;
		tick();
		while (!(o_shift_reg_empty_flag === 1'h1 &&
			o_transmit_interrupt_flag === 1'h1) && k < 3000) begin
			tick();
			k++;
		end
		tick(4);
		i_nine_bit_transmit_enable <= n;
		i_transmit_polarity_invert <= v;
		// Selects walk x1, x4 (both ways) and x16 over the eight modes
		i_wide_baud_divisor_select <= ~s;
		i_high_baud_select <= ~v;
		i_baud_div_low <= d;
		if (!s && !v)
			per <= 18'(d + 1);
		else if (s && v)
			per <= 18'(16 * (d + 1));
		else
			per <= 18'(4 * (d + 1));
		tick();
		rx_inv <= v;
		tick(4);
	endtask : cfg
	task automatic send(input logic [8:0] c, input logic exp);
		int k;
		logic was;
		k = 0;
		tick();
		while (o_transmit_interrupt_flag !== 1'h1 && k < 1500) begin
			tick();
			k++;
		end
		i_ninth_transmit_bit <= c[8];
		tick();
		i_hold_data <= c[7:0];
		i_hold_wr <= 1'h1;
		if (exp) q.push_back({i_nine_bit_transmit_enable, c});
		was = o_shift_reg_empty_flag;
		tick();
		i_hold_wr <= 1'h0;
		// Load takes one edge and the line register one more
		tick(2);
		#1;
		if (was === 1'h1 && i_serial_port_enable === 1'h1 &&
			i_clocked_mode_select === 1'h0)
			chk("start", 9'(`AST_LINE_START ^ rx_inv), 9'(link.tx_line));
	endtask : send
	////////////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'h0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			print_verdict();
		end
	end
	always @(posedge i_mclk) begin
		logic [9:0] e;
		if (rv === 1'h1) begin
			if (q.size() == 0)
				chk("unexpected", 9'h1FF, rd);
			else begin
				e = q.pop_front();
				chk("char", e[9] ? e[8:0] : {1'h0, e[7:0]},
					e[9] ? rd : {1'h0, rd[7:0]});
				chk("frame", 9'h000, 9'(rfe));
			end
		end
	end
	initial begin
		{i_hold_wr, i_ninth_transmit_bit, rx_inv, adet} = 4'h0;
		{i_clocked_mode_select, i_serial_port_enable} = 2'h0;
		{i_nine_bit_transmit_enable, i_transmit_polarity_invert} = 2'h0;
		{i_transmit_enable_bit, i_transmit_interrupt_enable} = 2'h0;
		{i_global_interrupt_enable, i_peripheral_interrupt_enable} = 2'h0;
		{i_high_baud_select, i_wide_baud_divisor_select} = 2'h3;
		{i_baud_div_low, i_baud_div_high, i_hold_data} = 24'h030000;
		per = 18'h00004;
		i_rst = 1'h1;
		void'($urandom(67695));
		tick(3);
		i_rst <= 1'h0;
		i_serial_port_enable <= 1'h1;
		tick(2);
		i_transmit_enable_bit <= 1'h1;
		tick(3);
		#1;
		chk("enable flag", 9'h001, 9'(o_transmit_interrupt_flag));
		for (m = 0; m < 8; m++) begin
			cfg(m[0], m[1], m[2]);
			repeat (3) send(9'($urandom % 512), 1'h1);
			$display("mode test %0d done", m);
		end
		cfg(1'h1, 1'h0, 1'h0);
		adet <= 1'h1;
		send({1'h1, 8'($urandom)}, 1'h1);
		send({1'h0, 8'($urandom)}, 1'h0);
		send({1'h1, 8'($urandom)}, 1'h1);
		cfg(1'h0, 1'h0, 1'h0);
		adet <= 1'h0;
		i_serial_port_enable <= 1'h0;
		send(9'h0A5, 1'h0);
		tick(100);
		#1;
		chk("refused", 9'h001, 9'(o_shift_reg_empty_flag));
		tick();
		i_serial_port_enable <= 1'h1;
		i_clocked_mode_select <= 1'h1;
		send(9'h15A, 1'h0);
		tick(100);
		#1;
		chk("refused sync", 9'h001, 9'(o_shift_reg_empty_flag));
		tick();
		i_clocked_mode_select <= 1'h0;
		$display("address and refusal test done");
		for (m = 0; m < 8; m++) begin
			{i_transmit_interrupt_enable, i_global_interrupt_enable,
				i_peripheral_interrupt_enable} <= 3'(m);
			tick(3);
			#1;
			chk("irq", 9'(m == 7), 9'(o_irq));
			tick();
		end
		send(9'($urandom % 256), 1'h1);
		tick(300);
		chk("drain", 9'h000, 9'(q.size()));
		$display("interrupt test done");
		print_verdict();
	end
endmodule : ast_tx_tb_top
`default_nettype wire
